// file: rtl/mrd_pkg.sv
`default_nettype none
// Shared constants for the medium-rate serial downlink framing ends
package mrd_pkg;

    // Clock of both ends
    localparam int CLK_NS = 10;

    // Merged output stream: 2 Mb/s, one bit every 500 ns
    localparam int OUT_BIT_NS = 500;
    localparam int OUT_HALF   = OUT_BIT_NS / CLK_NS / 2;

    // Number of customer inputs the carrier merges, and channel id width
    localparam int N_CH = 6;
    localparam int CH_W = 3;

    // Frame layout
    localparam int          SYNC_BITS       = 24;
    localparam logic [23:0] SYNC_WORD       = 24'hfaf320;
    localparam int          SYNC_BYTES      = 3;
    localparam int          CNT_POS         = 3;
    localparam int          MAX_FRAME_BITS  = 8192;
    localparam int          MAX_FRAME_BYTES = MAX_FRAME_BITS / 8;
    localparam int          LEADER_FRAMES   = 4;
    localparam int          FLUSH_BYTES     = 66;
    localparam logic [7:0]  FILL_BYTE       = 8'h00;

    // Merged word: channel id, start-of-frame flag, data byte
    localparam int WORD_BITS = CH_W + 1 + 8;

    // Customer formatter states
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_LEAD  = 4'b0010,
        ST_DATA  = 4'b0100,
        ST_FLUSH = 4'b1000
    } mrd_tx_state_e;

endpackage
`default_nettype wire

// file: rtl/mrd_link_if.sv
`timescale 1ns/1ns
`default_nettype none
// One clock and one NRZ data line per customer input
interface mrd_link_if #(
    parameter int N_CH = mrd_pkg::N_CH
);
    wire [N_CH-1:0] lclk;
    wire [N_CH-1:0] ldata;

    // Customer formatter drives its own lane
    modport customer (
        output lclk,
        output ldata
    );

    // Carrier multiplexer samples all lanes
    modport carrier (
        input lclk,
        input ldata
    );
endinterface
`default_nettype wire

// file: rtl/mrd_customer_tx.sv
`timescale 1ns/1ns
`default_nettype none
// Rules of the downlink this block serves
// - Carrier merges up to six inputs, 2 Mb/s
// - Customers keep summed input rate <= 1.4 Mb/s
// - Rate continuous, within 1 percent, during data-take
// - Clock may stop between valid data periods
// - Or clock runs, sync patterns stop
// - At least four leader frames before data
// - At least 66 bytes clocking after last frame
// - Fixed frame length, whole bytes, <= 8192 bits
// - Every frame starts with fixed 24-bit sync
// - Sync FAF320, MSB byte and bit first
// - Frame counter not repeating within 256 frames
// - Ground regenerates faster clock, pausing to equalize
// - Ground equipment holds lock despite errors, delay
// - Return is NRZ-L data with clock
// - Return data is frame synchronized
module mrd_customer_tx #(
    parameter int LANE        = 0,
    parameter int FRAME_BYTES = 64,
    parameter int HALF_DIV    = 40
) (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // Link toward the carrier
    mrd_link_if.customer    lk,
    // Period control
    input  wire logic       tx_en,
    input  wire logic       keep_clk,
    // Payload bytes from the instrument
    input  wire logic [7:0] in_data,
    input  wire logic       in_valid,
    output logic            in_ready,
    // Status
    output logic            leader_active,
    output logic            data_active,
    output logic            flush_active,
    output logic [7:0]      frame_count
);

    typedef logic [9:0] mrd_pos_t;

    localparam mrd_pos_t   LAST_POS  = mrd_pos_t'(FRAME_BYTES - 1);
    localparam mrd_pos_t   CNT_POS   = mrd_pos_t'(mrd_pkg::CNT_POS);
    localparam logic [2:0] LEAD_LAST = 3'(mrd_pkg::LEADER_FRAMES - 1);
    localparam logic [6:0] FLSH_LAST = 7'(mrd_pkg::FLUSH_BYTES - 1);
    localparam logic [15:0] DIV_LAST = 16'(HALF_DIV - 1);

    mrd_pkg::mrd_tx_state_e st_reg, st_next;
    mrd_pos_t               pos_reg, pos_next;
    logic [2:0]             lead_reg, lead_next;
    logic [6:0]             flush_reg, flush_next;
    logic [7:0]             frm_reg, frm_next;
    logic [7:0]             byte_next;
    logic                   take;

    logic [15:0] div_reg;
    logic        run_reg;
    logic        lclk_reg;
    logic [7:0]  sh_reg;
    logic [2:0]  bit_reg;
    logic        div_done;
    logic        fall;
    logic        bit_last;
    logic        stop;
    logic        load;

    // Link pins of this lane
    assign lk.lclk[LANE]  = lclk_reg;
    assign lk.ldata[LANE] = sh_reg[7];

    // Bit clock events
    assign div_done = run_reg && (div_reg == DIV_LAST);
    assign fall     = div_done && lclk_reg;
    assign bit_last = (bit_reg == 3'h7);
    // Clock halts only at a byte end when idle with tx_en and keep_clk both low
    assign stop     = fall && bit_last && (st_reg == mrd_pkg::ST_IDLE) && !tx_en && !keep_clk;
    // Next byte is taken at the byte boundary or when a stopped clock restarts
    assign load     = (fall && bit_last && !stop) || (!run_reg && (tx_en || keep_clk));

    // Next byte and sequencing of frames and periods
    always_comb begin
        st_next    = st_reg;
        pos_next   = pos_reg;
        lead_next  = lead_reg;
        flush_next = flush_reg;
        frm_next   = frm_reg;
        byte_next  = mrd_pkg::FILL_BYTE;
        take       = 1'b0;
        case (st_reg)
            mrd_pkg::ST_IDLE: begin
                // Clock may keep running with fill, no sync sent
                if (tx_en) begin
                    st_next   = mrd_pkg::ST_LEAD;
                    pos_next  = '0;
                    lead_next = '0;
                end
            end
            mrd_pkg::ST_LEAD, mrd_pkg::ST_DATA: begin
                // Sync word opens every frame, MSB byte first
                case (pos_reg)
                    10'h000: byte_next = mrd_pkg::SYNC_WORD[23:16];
                    10'h001: byte_next = mrd_pkg::SYNC_WORD[15:8];
                    10'h002: byte_next = mrd_pkg::SYNC_WORD[7:0];
                    default: byte_next = mrd_pkg::FILL_BYTE;
                endcase
                if (pos_reg == CNT_POS) begin
                    byte_next = frm_reg; // 8-bit counter, 256 frames per wrap
                end else if (pos_reg > CNT_POS && st_reg == mrd_pkg::ST_DATA && in_valid) begin
                    byte_next = in_data;
                    take      = 1'b1;
                end
                // Late payload is replaced by fill so the stream never gaps
                if (pos_reg == LAST_POS) begin
                    // Frames follow back to back at one fixed length
                    pos_next = '0;
                    frm_next = frm_reg + 8'h01;
                    if (!tx_en) begin
                        st_next    = mrd_pkg::ST_FLUSH;
                        flush_next = '0;
                    end else if (st_reg == mrd_pkg::ST_LEAD && lead_reg == LEAD_LAST) begin
                        st_next = mrd_pkg::ST_DATA; // four leader frames done
                    end else if (st_reg == mrd_pkg::ST_LEAD) begin
                        lead_next = lead_reg + 3'h1;
                    end
                end else begin
                    pos_next = pos_reg + 10'h001;
                end
            end
            mrd_pkg::ST_FLUSH: begin
                // Keep clocking fill to empty the carrier buffer
                if (flush_reg == FLSH_LAST) begin
                    st_next = mrd_pkg::ST_IDLE;
                end else begin
                    flush_next = flush_reg + 7'h01;
                end
            end
            default: begin
                st_next = mrd_pkg::ST_IDLE;
            end
        endcase
    end

    // Payload handshake completes on the load that consumes the byte
    assign in_ready = load && take;

    // Sequencer state
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg    <= mrd_pkg::ST_IDLE;
            pos_reg   <= '0;
            lead_reg  <= '0;
            flush_reg <= '0;
            frm_reg   <= '0;
        end else if (load) begin
            st_reg    <= st_next;
            pos_reg   <= pos_next;
            lead_reg  <= lead_next;
            flush_reg <= flush_next;
            frm_reg   <= frm_next;
        end
    end

    // Bit clock divider, fixed rate from the local clock
    always_ff @(posedge mclk) begin
        if (rst) begin
            run_reg  <= 1'b0;
            div_reg  <= '0;
            lclk_reg <= 1'b0;
        end else if (load && !run_reg) begin
            run_reg <= 1'b1;
            div_reg <= '0;
        end else if (stop) begin
            run_reg  <= 1'b0;
            div_reg  <= '0;
            lclk_reg <= 1'b0;
        end else if (div_done) begin
            div_reg  <= '0;
            lclk_reg <= !lclk_reg;
        end else if (run_reg) begin
            div_reg <= div_reg + 16'h0001;
        end
    end

    // Shifter, data moves only at falling edges or while stopped
    always_ff @(posedge mclk) begin
        if (rst) begin
            sh_reg  <= '0;
            bit_reg <= '0;
        end else if (load) begin
            sh_reg  <= byte_next;
            bit_reg <= '0;
        end else if (fall && !bit_last) begin
            sh_reg  <= {sh_reg[6:0], 1'b0};
            bit_reg <= bit_reg + 3'h1;
        end
    end

    // Status outputs
    assign leader_active = (st_reg == mrd_pkg::ST_LEAD);
    assign data_active   = (st_reg == mrd_pkg::ST_DATA);
    assign flush_active  = (st_reg == mrd_pkg::ST_FLUSH);
    assign frame_count   = frm_reg;

endmodule // mrd_customer_tx
`default_nettype wire

// file: rtl/mrd_carrier_mux.sv
`timescale 1ns/1ns
`default_nettype none
module mrd_carrier_mux #(
    parameter int N_CH        = mrd_pkg::N_CH,
    parameter int FRAME_BYTES = 64
) (
    // Clock and reset
    input  wire logic            mclk,
    input  wire logic            rst,
    // Customer inputs
    mrd_link_if.carrier          lk,
    // Merged NRZ-L output with clock
    input  wire logic            out_hold,
    output logic                 out_clk,
    output logic                 out_data,
    output logic                 out_word,
    // Per-channel status
    output logic [N_CH-1:0]      ch_locked,
    output logic [N_CH-1:0]      ch_overrun
);

    localparam logic [13:0] FB_LAST  = 14'(FRAME_BYTES * 8 - 1);
    // Last frame bit that still closes a forwarded byte; later bytes are sync
    localparam logic [13:0] PAY_LAST = 14'(FRAME_BYTES * 8 - mrd_pkg::SYNC_BITS - 1);
    localparam logic [7:0]  DIV_LAST = 8'(mrd_pkg::OUT_HALF - 1);
    localparam int          WB       = mrd_pkg::WORD_BITS;

    logic [N_CH-1:0] b_valid;
    logic [N_CH-1:0] b_pop;
    logic [8:0]      b_head [N_CH];

    // Per-input receiver, framer and two-entry buffer
    for (genvar g = 0; g < N_CH; g++) begin : g_ch
        logic [2:0]  ck_sync;
        logic [2:0]  dt_sync;
        logic        ck_lvl;
        logic        dt_lvl;
        logic        rise;
        logic [23:0] sh_reg;
        logic [23:0] sh_next;
        logic [2:0]  bit_reg;
        logic [13:0] fb_reg;
        logic        lock_reg;
        logic        sof_reg;
        logic        resync;
        logic        push;
        logic [8:0]  mem_reg [2];
        logic        wp_reg;
        logic        rp_reg;
        logic [1:0]  cnt_reg;
        logic        ovf_reg;

        // Three-stage sampling of the foreign clock and data
        always_ff @(posedge mclk) begin
            if (rst) begin
                ck_sync <= '0;
                dt_sync <= '0;
                ck_lvl  <= 1'b0;
                dt_lvl  <= 1'b0;
            end else begin
                ck_sync <= {ck_sync[1:0], lk.lclk[g]};
                dt_sync <= {dt_sync[1:0], lk.ldata[g]};
                if (ck_sync[2] == ck_sync[1]) ck_lvl <= ck_sync[1];
                if (dt_sync[2] == dt_sync[1]) dt_lvl <= dt_sync[1];
            end
        end

        // Sample on the rising edge, opposite the data change
        assign rise    = (ck_sync[2] == ck_sync[1]) && ck_sync[1] && !ck_lvl;
        assign sh_next = {sh_reg[22:0], dt_lvl};
        // Lock on sync when searching, else only at the frame boundary
        assign resync  = (sh_next == mrd_pkg::SYNC_WORD) && (!lock_reg || fb_reg == FB_LAST);
        assign push    = rise && lock_reg && !resync && (bit_reg == 3'h7) && (fb_reg <= PAY_LAST);

        // Frame synchronizer; no edges means nothing happens
        always_ff @(posedge mclk) begin
            if (rst) begin
                sh_reg   <= '0;
                bit_reg  <= '0;
                fb_reg   <= '0;
                lock_reg <= 1'b0;
                sof_reg  <= 1'b0;
            end else if (rise) begin
                sh_reg <= sh_next;
                if (resync) begin
                    lock_reg <= 1'b1;
                    fb_reg   <= '0;
                    bit_reg  <= '0;
                    sof_reg  <= 1'b1;
                end else begin
                    fb_reg  <= fb_reg + 14'h0001;
                    bit_reg <= bit_reg + 3'h1;
                    if (fb_reg == FB_LAST) lock_reg <= 1'b0; // sync missing
                    if (push) sof_reg <= 1'b0;
                end
            end
        end

        // Two-entry buffer, full drops the byte and flags overrun
        always_ff @(posedge mclk) begin
            if (rst) begin
                wp_reg     <= 1'b0;
                rp_reg     <= 1'b0;
                cnt_reg    <= '0;
                ovf_reg    <= 1'b0;
                mem_reg[0] <= '0;
                mem_reg[1] <= '0;
            end else begin
                if (push && cnt_reg != 2'h2) begin
                    mem_reg[wp_reg] <= {sof_reg, sh_next[7:0]};
                    wp_reg          <= !wp_reg;
                end
                if (push && cnt_reg == 2'h2) ovf_reg <= 1'b1;
                if (b_pop[g]) rp_reg <= !rp_reg;
                case ({push && cnt_reg != 2'h2, b_pop[g]})
                    2'b10:   cnt_reg <= cnt_reg + 2'h1;
                    2'b01:   cnt_reg <= cnt_reg - 2'h1;
                    default: cnt_reg <= cnt_reg;
                endcase
            end
        end

        assign b_valid[g]    = (cnt_reg != 2'h0);
        assign b_head[g]     = mem_reg[rp_reg];
        assign ch_locked[g]  = lock_reg;
        assign ch_overrun[g] = ovf_reg;
    end

    localparam int CH_W_T = mrd_pkg::CH_W;
    logic [CH_W_T-1:0] rr_reg;
    logic [CH_W_T-1:0] sel;
    logic              any;
    logic [WB-1:0]     word_reg;
    logic [3:0]        bitn_reg;
    logic [7:0]        div_reg;
    logic              run_reg;
    logic              oclk_reg;
    logic              div_done;
    logic              fall;
    logic              last;
    logic              load;

    // Round-robin pick after the last served input
    always_comb begin
        int idx;
        idx = 0;
        sel = rr_reg;
        any = 1'b0;
        for (int k = N_CH; k >= 1; k--) begin
            idx = (int'(rr_reg) + k) % N_CH;
            if (b_valid[idx]) begin
                sel = CH_W_T'(idx);
                any = 1'b1;
            end
        end
    end

    // Output bit clock, paused when nothing is queued
    assign div_done = run_reg && (div_reg == DIV_LAST);
    assign fall     = div_done && oclk_reg;
    assign last     = (bitn_reg == 4'(WB - 1));
    assign load     = any && !out_hold && (!run_reg || (fall && last));

    always_comb begin
        for (int k = 0; k < N_CH; k++) begin
            b_pop[k] = load && (int'(sel) == k);
        end
    end

    // Serializer of merged words, MSB first on NRZ-L
    always_ff @(posedge mclk) begin
        if (rst) begin
            rr_reg   <= '0;
            word_reg <= '0;
            bitn_reg <= '0;
            div_reg  <= '0;
            run_reg  <= 1'b0;
            oclk_reg <= 1'b0;
        end else if (load) begin
            rr_reg   <= sel;
            word_reg <= {sel, b_head[sel]};
            bitn_reg <= '0;
            div_reg  <= '0;
            run_reg  <= 1'b1;
            oclk_reg <= 1'b0;
        end else if (fall && last) begin
            run_reg  <= 1'b0;
            div_reg  <= '0;
            oclk_reg <= 1'b0;
        end else if (div_done) begin
            div_reg  <= '0;
            oclk_reg <= !oclk_reg;
            if (fall) begin
                word_reg <= {word_reg[WB-2:0], 1'b0};
                bitn_reg <= bitn_reg + 4'h1;
            end
        end else if (run_reg) begin
            div_reg <= div_reg + 8'h01;
        end
    end

    assign out_clk  = oclk_reg;
    assign out_data = word_reg[WB-1];
    assign out_word = load;

endmodule // mrd_carrier_mux
`default_nettype wire

// file: testbench/mrd_link_props.sv
`timescale 1ns/1ns
`default_nettype none
// Timing checks on lanes 0 and 1 and on the merged output
module mrd_link_props #(
    parameter int HD0         = 20,
    parameter int FRAME_BYTES = 5
) (
    // Clock and reset
    input wire logic       mclk,
    input wire logic       rst,
    // Link lanes
    input wire logic [5:0] lclk,
    input wire logic [5:0] ldata,
    // Merged output
    input wire logic       out_hold,
    input wire logic       out_clk,
    input wire logic       out_data,
    input wire logic       out_word
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    logic        lp_reg;
    logic        seen_reg;
    logic [23:0] sh_reg;
    logic [15:0] gap_reg;
    logic [15:0] hi_reg;
    logic [15:0] ohi_reg;
    logic [15:0] wgap_reg;
    logic        rise0;
    logic        hit;

    // Lane 0 rise and sync match
    assign rise0 = lclk[0] & ~lp_reg;
    assign hit   = rise0 && ({sh_reg[22:0], ldata[0]} == mrd_pkg::SYNC_WORD);

    // Lane 0 bit history and rises since last sync
    always_ff @(posedge mclk) begin
        if (rst) begin
            lp_reg   <= 1'b0;
            seen_reg <= 1'b0;
            sh_reg   <= '0;
            gap_reg  <= '0;
        end else begin
            lp_reg <= lclk[0];
            if (rise0) begin
                sh_reg   <= {sh_reg[22:0], ldata[0]};
                gap_reg  <= hit ? 16'h0000 : gap_reg + 16'h0001;
                seen_reg <= seen_reg | hit;
            end
        end
    end

    // High times of both clocks, cycles since last word
    always_ff @(posedge mclk) begin
        if (rst) begin
            hi_reg   <= '0;
            ohi_reg  <= '0;
            wgap_reg <= 16'hffff;
        end else begin
            hi_reg   <= lclk[0] ? hi_reg + 16'h0001 : 16'h0000;
            ohi_reg  <= out_clk ? ohi_reg + 16'h0001 : 16'h0000;
            wgap_reg <= out_word ? 16'h0000 : wgap_reg + {15'h0000, wgap_reg != 16'hffff};
        end
    end

    // Word load, then first rise and fall of the output clock
    sequence word_bit_s;
        out_word ##1 !out_clk ##25 $rose(out_clk) ##25 $fell(out_clk);
    endsequence

    reset_idle_a: assert property ($fell(rst) |-> lclk == 6'h00 && !out_clk && !out_word)
        else $error("link or output not idle after reset");
    lane_data_stable_a: assert property (lclk[0] |-> $stable(ldata[0]))
        else $error("lane data moved while clock high");
    lane_high_time_a: assert property ($fell(lclk[0]) |-> hi_reg == HD0)
        else $error("lane clock high time wrong");
    // Lane 1 runs with a half period of 5 cycles
    lane_one_period_a: assert property ($rose(lclk[1]) |-> lclk[1] [*5] ##1 !lclk[1])
        else $error("lane one clock high time wrong");
    sync_spacing_a: assert property (hit |-> !seen_reg || gap_reg >= FRAME_BYTES * 8 - 1)
        else $error("sync words closer than a frame");
    out_data_stable_a: assert property (out_clk |-> $stable(out_data))
        else $error("output data moved while clock high");
    out_high_time_a: assert property ($fell(out_clk) |-> ohi_reg == mrd_pkg::OUT_HALF)
        else $error("output clock high time wrong");
    word_timing_a: assert property (out_word |-> word_bit_s)
        else $error("word first bit timing wrong");
    word_spacing_a: assert property (out_word |-> wgap_reg >= 16'd599)
        else $error("words closer than twelve bits");
    hold_respect_a: assert property (out_hold |-> !out_word)
        else $error("word loaded during stall");
endmodule // mrd_link_props
`default_nettype wire

// file: testbench/test_medium_rate_serial_downlink_framing.sv
`timescale 1ns/1ns
`default_nettype none
module test_medium_rate_serial_downlink_framing;
    localparam int HD0 = 20;
    localparam int HD1 = 5;
    localparam int FB  = 5;

    logic        mclk       = 1'b0;
    logic        rst        = 1'b1;
    logic [1:0]  tx_en      = 2'b00;
    logic [1:0]  keep_clk   = 2'b00;
    logic [7:0]  in_data    = 8'h05;
    logic        in_valid   = 1'b0;
    logic        out_hold   = 1'b0;
    logic [31:0] rnd        = 32'he9c76c20;
    logic [1:0]  in_ready;
    logic [1:0]  flsh;
    logic        out_clk;
    logic        out_data;
    logic        out_word;
    logic [5:0]  ch_locked;
    logic [5:0]  ch_overrun;
    logic [11:0] exp_q[$];
    logic [11:0] sr;
    logic [7:0]  last_c;
    logic        lp0        = 1'b0;
    logic        ocp        = 1'b0;
    logic        took;
    int          fails      = 0;
    int          tests_run  = 0;
    int          taken      = 0;
    int          sofs       = 0;
    int          nb         = 0;
    int          r0         = 0;
    int          r1         = 0;
    int          fr         = 0;
    int          cyc        = 0;

    mrd_link_if #(.N_CH(6)) mrd_link_if_inst ();
    // Lanes without a customer: clock still, data changing
    assign mrd_link_if_inst.lclk[5:2]  = 4'h0;
    assign mrd_link_if_inst.ldata[5:2] = rnd[3:0];

    // Lane 0 sends periods, lane 1 only clocks fill
    for (genvar i = 0; i < 2; i++) begin : g_cust
        mrd_customer_tx #(.LANE(i), .FRAME_BYTES(FB), .HALF_DIV(i == 0 ? HD0 : HD1))
        mrd_customer_tx_inst (
            .mclk(mclk), .rst(rst), .lk(mrd_link_if_inst.customer),
            .tx_en(tx_en[i]), .keep_clk(keep_clk[i]),
            .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready[i]),
            .leader_active(), .data_active(), .flush_active(flsh[i]), .frame_count()
        );
    end

    mrd_carrier_mux #(.N_CH(6), .FRAME_BYTES(FB)) mrd_carrier_mux_inst (
        .mclk(mclk), .rst(rst), .lk(mrd_link_if_inst.carrier), .out_hold(out_hold),
        .out_clk(out_clk), .out_data(out_data), .out_word(out_word),
        .ch_locked(ch_locked), .ch_overrun(ch_overrun)
    );

    mrd_link_props #(.HD0(HD0), .FRAME_BYTES(FB)) mrd_link_props_inst (
        .mclk(mclk), .rst(rst), .lclk(mrd_link_if_inst.lclk), .ldata(mrd_link_if_inst.ldata),
        .out_hold(out_hold), .out_clk(out_clk), .out_data(out_data), .out_word(out_word)
    );

    // Free-running system clock
    initial begin
        forever #5 mclk = ~mclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic cmp(input logic [11:0] got, input logic [11:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic test_done();
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Frame starts carry a rising counter, other words match the notes
    task automatic chk_word(input logic [11:0] w);
        if (w[8] === 1'b1) begin
            if (sofs > 0) cmp(w, {4'h1, last_c + 8'h01}, "frame counter");
            last_c = w[7:0];
            sofs++;
        end else if (exp_q.size() > 0) begin
            cmp(w, exp_q.pop_front(), "payload word");
        end else begin
            cmp(w, 12'h000, "trailing word not fill");
        end
    endtask

    // Payload handshake, stall pattern and end of the period
    always @(posedge mclk) begin
        took = in_valid && in_ready[0] === 1'b1;
        if (took) begin
            exp_q.push_back({4'h0, in_data});
            taken++;
        end
        if (in_ready[1] !== 1'b0) cmp({11'h000, in_ready[1]}, 12'h000, "fill lane took");
        #1;
        rnd = lfsr(rnd);
        out_hold = rnd[7:4] == 4'h0;
        if (took) in_data = {4'h0, rnd[11:8]};
        // Close the period after three bytes; the closing frame carries fill
        if (taken == 3 && tx_en[0]) begin
            tx_en[0] = 1'b0;
            in_valid = 1'b0;
            exp_q.push_back(12'h000);
        end
    end

    // Lane 0 clock edges and output word capture
    always @(posedge mclk) begin
        if (mrd_link_if_inst.lclk[0] && !lp0) begin
            r0++;
            if (flsh[0]) fr++;
        end
        lp0 = mrd_link_if_inst.lclk[0];
        if (out_word) begin
            nb = 0;
        end else if (out_clk && !ocp) begin
            sr = {sr[10:0], out_data};
            nb++;
            if (nb == 12) chk_word(sr);
        end
        ocp = out_clk;
    end

    // Hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            test_done();
        end
    end

    // Main sequence: one valid period on lane 0
    initial begin
        repeat (20) @(posedge mclk);
        #1;
        rst = 1'b0;
        keep_clk[1] = 1'b1;
        tx_en[0] = 1'b1;
        in_valid = 1'b1;
        repeat (4) exp_q.push_back(12'h000);
        wait (flsh[0] === 1'b1);
        wait (flsh[0] === 1'b0);
        // Last fill byte still shifts out after the flush state ends
        repeat (16 * HD0 + 4) @(posedge mclk);
        r1 = r0;
        repeat (400) @(posedge mclk);
        cmp(12'(r0 - r1), 12'h000, "clock runs after flush");
        cmp(12'(fr >= 528), 12'h001, "flush too short");
        cmp(12'(sofs), 12'd8, "frame starts");
        cmp(12'(taken), 12'd3, "bytes taken");
        cmp(12'(exp_q.size()), 12'd0, "words missing");
        cmp({6'h00, ch_locked}, 12'h000, "lock after period");
        cmp({6'h00, ch_overrun}, 12'h000, "buffer overrun");
        test_done();
    end
endmodule // test_medium_rate_serial_downlink_framing
`default_nettype wire
